// ===== include/ecm_regs.svh
`ifndef ECM_REGS_SVH
`define ECM_REGS_SVH

// ----------------------------------------------------------------------
// Timing constants
// ----------------------------------------------------------------------
`define ECM_CLK_NS    10
`define ECM_TICK_NS   1000000
`define ECM_LIMIT_MS  250
`define ECM_TMR_W     9
`define ECM_TICK_W    17

`endif

// ===== include/ecm_pkg.sv
// ----------------------------------------------------------------------
// Shared types
// ----------------------------------------------------------------------
package ecm_pkg;

  typedef enum logic [1:0] {
    ST_OFF,
    ST_ON,
    ST_CLOSE_WAIT,
    ST_LOCKOUT
  } ecm_state_t;

endpackage : ecm_pkg

// ===== core/ecm_tick.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecm_regs.svh"

module ecm_tick #(
  parameter int TICK_CYCLES = `ECM_TICK_NS / `ECM_CLK_NS
) (
  input  wire logic clk_in,   // System clock
  input  wire logic rst_in,   // Async reset, active high
  output var  logic tick_out  // One-cycle pulse every tick period
);

  typedef struct packed {
    logic [`ECM_TICK_W-1:0] cnt;
    logic                   tick;
  } ecm_tick_regs_t;

  ecm_tick_regs_t r;
  ecm_tick_regs_t next_r;

  // ----------------------------------------------------------------------
  // Free-running divider
  // ----------------------------------------------------------------------
  always_comb begin
    next_r      = r;
    next_r.tick = 1'b0;
    if (r.cnt == `ECM_TICK_W'(TICK_CYCLES - 1)) begin
      next_r.cnt  = '0;
      next_r.tick = 1'b1;  // RULE12
    end else begin
      next_r.cnt = r.cnt + `ECM_TICK_W'(1);
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign tick_out = r.tick;

  chk_tick_single_pulse: assert property (@(posedge clk_in) disable iff (rst_in) // RULE12
    r.tick |=> !r.tick)
    else $error("tick lasted more than one cycle");

endmodule : ecm_tick
`default_nettype wire

// ===== core/ecm_contact_monitor.sv
`timescale 1ns/1ps
`default_nettype none
`include "ecm_regs.svh"

// Contract
// [RULE1] Per-output mode: one-channel or two-channel
// [RULE2] Monitoring off by default; disabled means unchecked; code still times closure in ST_CLOSE_WAIT
// [RULE3] One feedback input may serve several outputs
// [RULE4] One-channel: reset needs feedback closed
// [RULE5] One-channel: feedback ignored while outputs on
// [RULE6] Contacts close within 250 ms of off
// [RULE7] Two-channel: reset needs both feedbacks closed
// [RULE8] Two-channel: matched changes while on tolerated
// [RULE9] Two-channel: mismatch over 250 ms locks out
// [RULE10] Lockout holds until cleared, run, clear request
// [RULE11] One-channel: not closed 250 ms after off
// [RULE12] Timers use 1 ms tick, restart on end
module ecm_contact_monitor
  import ecm_pkg::*;
#(
  parameter int NUM_OUT     = 2,
  parameter int NUM_FB      = 2,
  parameter int SELW        = $clog2(NUM_FB),
  parameter int TICK_CYCLES = `ECM_TICK_NS / `ECM_CLK_NS
) (
  input  wire logic                     clk_in,                 // System clock
  input  wire logic                     rst_in,                 // Async reset, active high
  input  wire logic [NUM_FB-1:0]        fb_contact_in,          // Feedback pins, 1 = closed
  input  wire logic [NUM_OUT-1:0]       run_request_in,         // Safety logic wants output on
  input  wire logic [NUM_OUT-1:0]       reset_request_in,       // Manual or automatic reset
  input  wire logic [NUM_OUT-1:0]       fault_clear_request_in, // Manual fault reset
  input  wire logic [NUM_OUT-1:0]       mon_enable_in,          // Monitoring enabled per output
  input  wire logic [NUM_OUT-1:0]       two_channel_in,         // 1 = two-channel mode
  input  wire logic [NUM_OUT*SELW-1:0]  sel_a_in,               // First feedback index per output
  input  wire logic [NUM_OUT*SELW-1:0]  sel_b_in,               // Second feedback index
  output var  logic [NUM_OUT-1:0]       safety_switch_output_out, // Output drive, registered
  output var  logic [NUM_OUT-1:0]       lockout_out             // Lockout flag, registered
);

  localparam logic [`ECM_TMR_W-1:0] LIMIT = `ECM_TMR_W'(`ECM_LIMIT_MS);
  localparam logic [`ECM_TMR_W-1:0] ONE   = `ECM_TMR_W'(1);

  typedef struct packed {
    logic [NUM_FB-1:0]                     sync1;
    logic [NUM_FB-1:0]                     sync2;
    ecm_state_t [NUM_OUT-1:0]              st;
    logic [NUM_OUT-1:0][`ECM_TMR_W-1:0]    cnt;
    logic [NUM_OUT-1:0]                    out;
    logic [NUM_OUT-1:0]                    lock;
  } ecm_regs_t;

  ecm_regs_t          r;
  ecm_regs_t          next_r;
  logic               tick;
  logic [NUM_OUT-1:0] ca;
  logic [NUM_OUT-1:0] cb;

  // ----------------------------------------------------------------------
  // Millisecond tick
  // ----------------------------------------------------------------------
  ecm_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .tick_out (tick)
  );

  // ----------------------------------------------------------------------
  // Feedback routing per output
  // ----------------------------------------------------------------------
  // Any output may pick any synchronised input, so one contact string can
  // be shared; in one-channel mode the second channel mirrors the first.
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_route
    assign ca[g] = r.sync2[sel_a_in[g*SELW +: SELW]];                       // RULE3
    assign cb[g] = two_channel_in[g] ? r.sync2[sel_b_in[g*SELW +: SELW]]    // RULE1
                                     : ca[g];
  end

  // ----------------------------------------------------------------------
  // Per-output supervision
  // ----------------------------------------------------------------------
  always_comb begin
    logic mis;
    logic ok;
    mis    = 1'b0;
    ok     = 1'b0;
    next_r = r;
    next_r.sync1 = fb_contact_in;
    next_r.sync2 = r.sync1;
    for (int i = 0; i < NUM_OUT; i++) begin
      mis = mon_enable_in[i] && two_channel_in[i] && (ca[i] != cb[i]);
      // Disabled monitoring always reads as good
      ok  = !mon_enable_in[i] || (ca[i] && cb[i]);                     // RULE2
      case (r.st[i])
        ST_OFF, ST_ON: begin
          // Discrepancy timer runs only while the mismatch lasts
          if (!mis) begin
            next_r.cnt[i] = '0;                                        // RULE12
          end else if (tick) begin
            next_r.cnt[i] = r.cnt[i] + ONE;
          end
          if (mis && tick && r.cnt[i] == LIMIT) begin
            next_r.st[i] = ST_LOCKOUT;                                 // RULE9
          end else if (r.st[i] == ST_OFF) begin
            if (run_request_in[i] && reset_request_in[i] && ok) begin
              next_r.st[i]  = ST_ON;                                   // RULE4 RULE7
            end
          end else if (!run_request_in[i]) begin
            next_r.cnt[i] = '0;
            if (mon_enable_in[i] && !two_channel_in[i]) begin
              next_r.st[i] = ST_CLOSE_WAIT;                            // RULE6
            end else begin
              next_r.st[i] = ST_OFF;
            end
          end
          // One-channel feedback is not looked at while on; two-channel
          // matched changes never reach the timer above
        end                                                            // RULE5 RULE8
        ST_CLOSE_WAIT: begin
          if (ca[i]) begin
            next_r.st[i]  = ST_OFF;
            next_r.cnt[i] = '0;                                        // RULE12
          end else if (tick) begin
            // Trip on the tick after the 250th, so a contact that closes just
            // inside its allowance is never faulted
            if (r.cnt[i] == LIMIT) begin
              next_r.st[i] = ST_LOCKOUT;                               // RULE11
            end else begin
              next_r.cnt[i] = r.cnt[i] + ONE;
            end
          end
        end
        ST_LOCKOUT: begin
          // Leaves to off, never on: a normal reset is still required
          next_r.cnt[i] = '0;
          if (fault_clear_request_in[i] && run_request_in[i] && ok && !mis) begin
            next_r.st[i] = ST_OFF;                                     // RULE10
          end
        end
        default: begin
          next_r.st[i]  = ST_OFF;
          next_r.cnt[i] = '0;
        end
      endcase
      next_r.out[i]  = (next_r.st[i] == ST_ON);
      next_r.lock[i] = (next_r.st[i] == ST_LOCKOUT);                   // RULE10
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign safety_switch_output_out = r.out;
  assign lockout_out              = r.lock;

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  for (genvar g = 0; g < NUM_OUT; g++) begin : g_chk
    chk_one_ch_reset: assert property (@(posedge clk_in) disable iff (rst_in) // RULE4
      $rose(r.out[g]) && $past(mon_enable_in[g] && !two_channel_in[g]) |-> $past(ca[g]))
      else $error("one-channel output turned on with feedback open");

    chk_two_ch_reset: assert property (@(posedge clk_in) disable iff (rst_in) // RULE7
      $rose(r.out[g]) && $past(mon_enable_in[g] && two_channel_in[g])
        |-> $past(ca[g] && cb[g]))
      else $error("two-channel output turned on without both feedbacks closed");

    chk_lock_needs_mon: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
      $rose(r.lock[g]) |-> $past(mon_enable_in[g]))
      else $error("lockout raised with monitoring disabled");

    chk_on_ignores_fb: assert property (@(posedge clk_in) disable iff (rst_in) // RULE5
      r.out[g] && run_request_in[g] && mon_enable_in[g] && !two_channel_in[g] |=> r.out[g])
      else $error("one-channel output dropped while run held");

    chk_match_no_fault: assert property (@(posedge clk_in) disable iff (rst_in) // RULE8
      $rose(r.lock[g]) && $past(two_channel_in[g]) |-> $past(ca[g] != cb[g]))
      else $error("two-channel lockout without discrepancy");

    chk_disc_limit: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
      $rose(r.lock[g]) && $past(two_channel_in[g]) |-> $past(r.cnt[g]) == LIMIT && $past(tick))
      else $error("discrepancy lockout at wrong time");

    chk_disc_lock: assert property (@(posedge clk_in) disable iff (rst_in) // RULE9
      (r.st[g] == ST_ON || r.st[g] == ST_OFF) && mon_enable_in[g] && two_channel_in[g]
        && (ca[g] != cb[g]) && tick && r.cnt[g] == LIMIT |=> r.lock[g])
      else $error("discrepancy past limit did not lock out");

    chk_close_lock: assert property (@(posedge clk_in) disable iff (rst_in) // RULE11
      $rose(r.lock[g]) && $past(!two_channel_in[g])
        |-> $past(r.st[g] == ST_CLOSE_WAIT && !ca[g] && r.cnt[g] == LIMIT))
      else $error("one-channel lockout without closure timeout");

    chk_lock_off: assert property (@(posedge clk_in) disable iff (rst_in) // RULE10
      r.lock[g] |-> !r.out[g])
      else $error("output on during lockout");

    chk_lock_release: assert property (@(posedge clk_in) disable iff (rst_in) // RULE10
      $fell(r.lock[g]) |-> $past(fault_clear_request_in[g] && run_request_in[g]) && !r.out[g])
      else $error("lockout left without clear request and run");

    chk_timer_restart: assert property (@(posedge clk_in) disable iff (rst_in) // RULE12
      r.st[g] == ST_CLOSE_WAIT && ca[g] |=> r.cnt[g] == '0 && r.st[g] == ST_OFF)
      else $error("closure timer not restarted");

    chk_close_timeout: assert property (@(posedge clk_in) disable iff (rst_in) // RULE11
      r.st[g] == ST_CLOSE_WAIT && !ca[g] && tick && r.cnt[g] == LIMIT |=> r.lock[g])
      else $error("closure timeout did not lock out");

    chk_mon_off_direct: assert property (@(posedge clk_in) disable iff (rst_in) // RULE2
      r.st[g] == ST_OFF && !mon_enable_in[g] && run_request_in[g] && reset_request_in[g]
        |=> r.out[g])
      else $error("unmonitored output refused a reset");
  end

endmodule : ecm_contact_monitor
`default_nettype wire

// ===== sim/ecm_relay_model.sv
`timescale 1ns/1ps
`default_nettype none

// ----------------------------------------------------------------------
// Force-guided relay with one normally closed monitor contact
// ----------------------------------------------------------------------
module ecm_relay_model #(
  parameter int DLY = 20
) (
  input  wire logic clk_in,  // System clock
  input  wire logic coil_in, // Coil drive from a safety output
  input  wire logic weld_in, // Test fault: contact held open
  output var  logic fb_out   // Monitor contact, 1 = closed
);
  int   cnt = 0;
  logic pos = 1'b0;

  // Armature follows the coil after a fixed delay, well under 250 ms
  always @(posedge clk_in) begin
    if (coil_in !== pos) begin
      cnt <= cnt + 1;
      if (cnt >= DLY) begin
        pos <= coil_in;
        cnt <= 0;
      end
    end else begin
      cnt <= 0;
    end
  end

  assign fb_out = !(pos | weld_in);
endmodule : ecm_relay_model

`default_nettype wire

// ===== sim/ecm_contact_monitor_test.sv
`timescale 1ns/1ps
`default_nettype none

module ecm_contact_monitor_test;
  import ecm_pkg::*;
  logic       clk_in = 1'b0;
  logic       rst_in = 1'b1;
  logic [1:0] run, rreq, clr, mon, two, sa, sb, weld;
  logic [1:0] fb, out, lock;
  int         fail_count = 0;
  int         total_checks = 0;

  always #5 clk_in = ~clk_in;

  ecm_contact_monitor #(.TICK_CYCLES(4)) uut (
    .clk_in(clk_in), .rst_in(rst_in), .fb_contact_in(fb),
    .run_request_in(run), .reset_request_in(rreq),
    .fault_clear_request_in(clr), .mon_enable_in(mon),
    .two_channel_in(two), .sel_a_in(sa), .sel_b_in(sb),
    .safety_switch_output_out(out), .lockout_out(lock));
  ecm_relay_model rly0 (.clk_in(clk_in), .coil_in(|out), .weld_in(weld[0]), .fb_out(fb[0]));
  ecm_relay_model rly1 (.clk_in(clk_in), .coil_in(|out), .weld_in(weld[1]), .fb_out(fb[1]));

  task step(input int n);
    repeat (n) @(posedge clk_in);
  endtask : step

  task chk(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t value mismatch", $time);
    end
  endtask : chk

  task go(input int i);
    @(posedge clk_in); run[i] <= 1'b1; rreq[i] <= 1'b1;
    @(posedge clk_in); rreq[i] <= 1'b0; #1;
  endtask : go

  task stop(input int i);
    @(posedge clk_in); run[i] <= 1'b0;
    @(posedge clk_in); #1;
  endtask : stop

  task set_weld(input logic [1:0] w, input int n);
    @(posedge clk_in); weld <= w;
    step(n);
  endtask : set_weld

  // Cycles until lockout, bounded by hi
  task wait_lock(input int i, input int lo, input int hi);
    int n;
    n = 0;
    while (lock[i] !== 1'b1 && n <= hi) begin
      @(posedge clk_in); #1; n++;
    end
    chk(n >= lo && n <= hi, 1'b1);
  endtask : wait_lock

  task t_off;
    set_weld(2'b01, 4);
    go(0); chk(out[0], 1'b1);
    stop(0); step(1100); #1; chk(lock[0], 1'b0);
    set_weld(2'b00, 30);
    $display("test off done");
  endtask : t_off

  task t_one;
    mon <= 2'b11;
    set_weld(2'b01, 4);
    go(0); chk(out[0], 1'b0);
    go(1); chk(out[1], 1'b0);
    set_weld(2'b00, 4);
    go(0); chk(out[0], 1'b1);
    go(1); chk(out[1], 1'b1);
    step(40); #1; chk(out[0], 1'b1);
    stop(1); stop(0); chk(out[0], 1'b0);
    step(1100); #1; chk(lock[0], 1'b0);
    chk(lock[1], 1'b0);
    $display("test one done");
  endtask : t_one

  task t_lock;
    go(0); step(30);
    set_weld(2'b01, 0);
    stop(0); wait_lock(0, 1001, 1004);
    chk(out[0], 1'b0);
    @(posedge clk_in); clr[0] <= 1'b1;
    step(4); #1; chk(lock[0], 1'b1);
    @(posedge clk_in); run[0] <= 1'b1;
    step(4); #1; chk(lock[0], 1'b1);
    @(posedge clk_in); clr[0] <= 1'b0;
    set_weld(2'b00, 6); #1; chk(lock[0], 1'b1);
    @(posedge clk_in); clr[0] <= 1'b1;
    step(2); #1; chk(lock[0], 1'b0);
    chk(out[0], 1'b0);
    @(posedge clk_in); clr[0] <= 1'b0;
    go(0); chk(out[0], 1'b1);
    stop(0); step(30);
    $display("test lock done");
  endtask : t_lock

  task t_two;
    two <= 2'b10; sb <= 2'b10;
    set_weld(2'b11, 4);
    go(1); chk(out[1], 1'b0);
    set_weld(2'b10, 4);
    go(1); chk(out[1], 1'b0);
    set_weld(2'b00, 4);
    go(1); chk(out[1], 1'b1);
    step(40); #1; chk(out[1], 1'b1); chk(lock[1], 1'b0);
    stop(1); step(30);
    set_weld(2'b10, 600); #1; chk(lock[1], 1'b0);
    set_weld(2'b00, 10);
    set_weld(2'b10, 0); wait_lock(1, 1003, 1006);
    chk(out[1], 1'b0);
    $display("test two done");
  endtask : t_two

  task tally_and_finish;
    $display("checks %0d failures %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : tally_and_finish

  initial begin
    {run, rreq, clr, mon, two, sa, sb, weld} = '0;
    step(2);
    rst_in <= 1'b0;
    t_off;
    t_one;
    t_lock;
    t_two;
    tally_and_finish;
  end

  // Tests need about 5100 cycles
  initial begin
    #200000;
    fail_count++;
    tally_and_finish;
  end
endmodule : ecm_contact_monitor_test

`default_nettype wire
